// File: rtl/rssl_map.vh
`ifndef RSSL_MAP_VH
`define RSSL_MAP_VH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define RSSL_IDX_SWCFG      10'h05F
`define RSSL_IDX_STATUS     10'h070
`define RSSL_IDX_POS_LATCH  10'h071
`define RSSL_IDX_ENC_LATCH  10'h072
`define RSSL_IDX_VLIM_L     10'h073
`define RSSL_IDX_VLIM_R     10'h074
`define RSSL_IDX_WAIT       10'h075
// ****************************************
// Switch configuration fields
// ****************************************
`define RSSL_B_STOP_L_EN    0
`define RSSL_B_STOP_R_EN    1
`define RSSL_B_POL_L        2
`define RSSL_B_POL_R        3
`define RSSL_B_SWAP         4
`define RSSL_B_LATCH_L_ACT  5
`define RSSL_B_LATCH_L_INA  6
`define RSSL_B_LATCH_R_ACT  7
`define RSSL_B_LATCH_R_INA  8
`define RSSL_B_LATCH_ENC    9
`define RSSL_B_STALL_HALT   10
`define RSSL_B_SOFTSTOP     11
`define RSSL_B_FINAL_HALT_VELOCITY_L_EN   12
`define RSSL_B_FINAL_HALT_VELOCITY_R_EN   13
`define RSSL_B_VSRC_ENC     14
`define RSSL_SWCFG_MASK     32'h0000_7FFF
`define RSSL_SWCFG_RST      32'h0000_0000
// ****************************************
// Status fields
// ****************************************
`define RSSL_S_SW_L         0
`define RSSL_S_SW_R         1
`define RSSL_S_LATCH_L      2
`define RSSL_S_LATCH_R      3
`define RSSL_S_VIRT_L       4
`define RSSL_S_VIRT_R       5
`define RSSL_S_STALL        6
`define RSSL_S_HALT         7
`define RSSL_S_WAITING      8
`define RSSL_W1C_MASK       32'h0000_004C
// ****************************************
// Other reset values and responses
// ****************************************
`define RSSL_VLIM_L_RST     32'h8000_0000
`define RSSL_VLIM_R_RST     32'h7FFF_FFFF
`define RSSL_WAIT_RST       32'h0000_0000
`define RSSL_RESP_OKAY      2'h0
`define RSSL_RESP_SLVERR    2'h2
`endif

// File: rtl/rssl_top.v
// Overview of operation
// - Bit 14 picks ramp position or encoder position for virtual limits.
// - Bit 13 set: halt while right virtual limit active.
// - Bit 12 set: halt while left virtual limit active.
// - Bit 11 picks hard stop (0) or soft decelerating stop (1).
// - Switch and virtual stops apply only when enabled and velocity sign matches switch side.
// - Hard stop still holds the motor for the standstill wait time.
// - Bit 10 halts on stall event; clearing bit releases the motor.
// - Bit 9 copies encoder position to encoder latch on latch events.
// - Bit 8 latches position on right switch going inactive.
// - Bit 7 latches position on right switch going active.
// - Bit 6 latches position on left switch going inactive.
// - Bit 5 latches position on left switch going active.
// - Bit 4 exchanges left and right switch inputs.
// - Polarity bit 0 means high active, 1 means low active.
// - Stop enable halts while switch active; resumes once the standstill wait has run out after release.
`timescale 1ns/1ps
`include "rssl_map.vh"
module rssl_top (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        left_switch_input,
  input  wire        right_switch_input,
  input  wire [31:0] ramp_actual_position,
  input  wire [31:0] encoder_position,
  input  wire [31:0] ramp_velocity,
  input  wire        stall_event,
  output reg         motor_halt_r,
  output reg         halt_soft_r,
  output reg         halt_waiting_r
);

  // ****************************************
  // Functions
  // ****************************************
  function [31:0] rssl_merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer      i;
    begin
      rssl_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          rssl_merge[i*8 +: 8] = dat[i*8 +: 8];
        end
      end
    end
  endfunction

  function rssl_hit;
    input [31:0] addr;
    input [9:0]  idx;
    begin
      rssl_hit = (addr[11:2] == idx) && (addr[31:12] == 20'h0_0000);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg  [31:0] swcfg_r;
  reg  [31:0] vlim_l_r;
  reg  [31:0] vlim_r_r;
  reg  [31:0] wait_r;
  reg  [31:0] pos_latch_r;
  reg  [31:0] enc_latch_r;
  reg         latch_l_flag_r;
  reg         latch_r_flag_r;
  reg         stall_stop_r;
  reg  [31:0] wait_cnt_r;
  reg  [2:0]  sync_l_r;
  reg  [2:0]  sync_r_r;
  reg         filt_l_r;
  reg         filt_r_r;
  reg         act_l_prev_r;
  reg         act_r_prev_r;
  reg  [31:0] awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         aw_held_r;
  reg         w_held_r;

  // ****************************************
  // Switch conditioning
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_l_r <= 3'h0;
      sync_r_r <= 3'h0;
      filt_l_r <= 1'b0;
      filt_r_r <= 1'b0;
    end else begin
      sync_l_r <= {sync_l_r[1:0], left_switch_input};
      sync_r_r <= {sync_r_r[1:0], right_switch_input};
      if (sync_l_r[1] == sync_l_r[2]) begin
        filt_l_r <= sync_l_r[2];
      end
      if (sync_r_r[1] == sync_r_r[2]) begin
        filt_r_r <= sync_r_r[2];
      end
    end
  end

  wire swap   = swcfg_r[`RSSL_B_SWAP];
  wire raw_l  = swap ? filt_r_r : filt_l_r;
  wire raw_r  = swap ? filt_l_r : filt_r_r;
  wire act_l  = raw_l ^ swcfg_r[`RSSL_B_POL_L];
  wire act_r  = raw_r ^ swcfg_r[`RSSL_B_POL_R];
  wire rise_l = act_l & ~act_l_prev_r;
  wire fall_l = ~act_l & act_l_prev_r;
  wire rise_r = act_r & ~act_r_prev_r;
  wire fall_r = ~act_r & act_r_prev_r;

  wire latch_l_ev = (rise_l & swcfg_r[`RSSL_B_LATCH_L_ACT]) |
                    (fall_l & swcfg_r[`RSSL_B_LATCH_L_INA]);
  wire latch_r_ev = (rise_r & swcfg_r[`RSSL_B_LATCH_R_ACT]) |
                    (fall_r & swcfg_r[`RSSL_B_LATCH_R_INA]);

  // ****************************************
  // Stop decision
  // ****************************************
  wire [31:0] vpos = swcfg_r[`RSSL_B_VSRC_ENC] ? encoder_position
                                               : ramp_actual_position;
  wire virt_l = $signed(vpos) < $signed(vlim_l_r);
  wire virt_r = $signed(vpos) > $signed(vlim_r_r);
  wire vel_neg = ramp_velocity[31];
  wire vel_pos = ~ramp_velocity[31] & (ramp_velocity != 32'h0000_0000);
  wire stop_l = vel_neg &
                ((act_l & swcfg_r[`RSSL_B_STOP_L_EN]) |
                 (virt_l & swcfg_r[`RSSL_B_FINAL_HALT_VELOCITY_L_EN]));
  wire stop_r = vel_pos &
                ((act_r & swcfg_r[`RSSL_B_STOP_R_EN]) |
                 (virt_r & swcfg_r[`RSSL_B_FINAL_HALT_VELOCITY_R_EN]));
  wire stop_now = stop_l | stop_r | stall_stop_r;

  // ****************************************
  // Bus decode
  // ****************************************
  wire wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire wr_cfg  = wr_fire & rssl_hit(awaddr_r, `RSSL_IDX_SWCFG);
  wire wr_stat = wr_fire & rssl_hit(awaddr_r, `RSSL_IDX_STATUS);
  wire wr_vl   = wr_fire & rssl_hit(awaddr_r, `RSSL_IDX_VLIM_L);
  wire wr_vr   = wr_fire & rssl_hit(awaddr_r, `RSSL_IDX_VLIM_R);
  wire wr_wt   = wr_fire & rssl_hit(awaddr_r, `RSSL_IDX_WAIT);
  wire wr_ro   = rssl_hit(awaddr_r, `RSSL_IDX_POS_LATCH) |
                 rssl_hit(awaddr_r, `RSSL_IDX_ENC_LATCH);
  wire wr_ok   = wr_cfg | wr_stat | wr_vl | wr_vr | wr_wt | (wr_fire & wr_ro);
  wire [31:0] w1c = rssl_merge(32'h0000_0000, wdata_r, wstrb_r) &
                    `RSSL_W1C_MASK;
  wire [31:0] cfg_nxt = rssl_merge(swcfg_r, wdata_r, wstrb_r) &
                        `RSSL_SWCFG_MASK;

  wire [31:0] status = {23'h00_0000, halt_waiting_r, motor_halt_r,
                        stall_stop_r, virt_r, virt_l, latch_r_flag_r,
                        latch_l_flag_r, act_r, act_l};

  // ****************************************
  // Register file and capture
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      swcfg_r        <= `RSSL_SWCFG_RST;
      vlim_l_r       <= `RSSL_VLIM_L_RST;
      vlim_r_r       <= `RSSL_VLIM_R_RST;
      wait_r         <= `RSSL_WAIT_RST;
      pos_latch_r    <= 32'h0000_0000;
      enc_latch_r    <= 32'h0000_0000;
      latch_l_flag_r <= 1'b0;
      latch_r_flag_r <= 1'b0;
      stall_stop_r   <= 1'b0;
      act_l_prev_r   <= 1'b0;
      act_r_prev_r   <= 1'b0;
    end else begin
      act_l_prev_r <= act_l;
      act_r_prev_r <= act_r;
      if (wr_cfg) begin
        swcfg_r <= cfg_nxt;
      end
      if (wr_vl) begin
        vlim_l_r <= rssl_merge(vlim_l_r, wdata_r, wstrb_r);
      end
      if (wr_vr) begin
        vlim_r_r <= rssl_merge(vlim_r_r, wdata_r, wstrb_r);
      end
      if (wr_wt) begin
        wait_r <= rssl_merge(wait_r, wdata_r, wstrb_r);
      end
      if (latch_l_ev | latch_r_ev) begin
        pos_latch_r <= ramp_actual_position;
        if (swcfg_r[`RSSL_B_LATCH_ENC]) begin
          enc_latch_r <= encoder_position;
        end
      end
      if (latch_l_ev) begin
        latch_l_flag_r <= 1'b1;
      end else if (wr_stat & w1c[`RSSL_S_LATCH_L]) begin
        latch_l_flag_r <= 1'b0;
      end
      if (latch_r_ev) begin
        latch_r_flag_r <= 1'b1;
      end else if (wr_stat & w1c[`RSSL_S_LATCH_R]) begin
        latch_r_flag_r <= 1'b0;
      end
      if (!swcfg_r[`RSSL_B_STALL_HALT]) begin
        stall_stop_r <= 1'b0;
      end else if (stall_event) begin
        stall_stop_r <= 1'b1;
      end else if (wr_stat & w1c[`RSSL_S_STALL]) begin
        stall_stop_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Halt and standstill wait
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      motor_halt_r   <= 1'b0;
      halt_soft_r    <= 1'b0;
      halt_waiting_r <= 1'b0;
      wait_cnt_r     <= 32'h0000_0000;
    end else begin
      halt_soft_r <= swcfg_r[`RSSL_B_SOFTSTOP];
      if (stop_now) begin
        motor_halt_r   <= 1'b1;
        halt_waiting_r <= 1'b0;
        wait_cnt_r     <= wait_r;
      end else if (motor_halt_r && wait_cnt_r != 32'h0000_0000) begin
        halt_waiting_r <= 1'b1;
        wait_cnt_r     <= wait_cnt_r - 32'h0000_0001;
      end else begin
        motor_halt_r   <= 1'b0;
        halt_waiting_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RSSL_RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 32'h0000_0000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RSSL_RESP_OKAY : `RSSL_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RSSL_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RSSL_RESP_OKAY;
        if (rssl_hit(s_axi_araddr, `RSSL_IDX_SWCFG)) begin
          s_axi_rdata <= swcfg_r;
        end else if (rssl_hit(s_axi_araddr, `RSSL_IDX_STATUS)) begin
          s_axi_rdata <= status;
        end else if (rssl_hit(s_axi_araddr, `RSSL_IDX_POS_LATCH)) begin
          s_axi_rdata <= pos_latch_r;
        end else if (rssl_hit(s_axi_araddr, `RSSL_IDX_ENC_LATCH)) begin
          s_axi_rdata <= enc_latch_r;
        end else if (rssl_hit(s_axi_araddr, `RSSL_IDX_VLIM_L)) begin
          s_axi_rdata <= vlim_l_r;
        end else if (rssl_hit(s_axi_araddr, `RSSL_IDX_VLIM_R)) begin
          s_axi_rdata <= vlim_r_r;
        end else if (rssl_hit(s_axi_araddr, `RSSL_IDX_WAIT)) begin
          s_axi_rdata <= wait_r;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RSSL_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// File: test/rssl_assertions.sv
`timescale 1ns/1ps
// ****************
// Bus and halt checks
// ****************
module rssl_assertions (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        motor_halt_r,
  input wire        halt_waiting_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_W_ANS: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer not on time");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_B_REL: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not on time");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_R_BAD: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[31:12] != 20'h0_0000
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_WAIT_HALT: assert property (
    halt_waiting_r |-> motor_halt_r)
    else $error("waiting without halt");
  AST_WAIT_SRC: assert property (
    $rose(halt_waiting_r) |-> $past(motor_halt_r))
    else $error("wait started without stop");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(halt_waiting_r));
  cover property ($fell(motor_halt_r));
endmodule

// File: test/rssl_partner.sv
`timescale 1ns/1ps
// ****************
// Switch contacts and encoder
// ****************
module rssl_partner (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        left_on,
  input  wire        right_on,
  input  wire        enc_run,
  output wire        left_switch_input,
  output wire        right_switch_input,
  output reg  [31:0] encoder_position
);
  // Contacts drive the pin level directly
  assign left_switch_input = left_on;
  assign right_switch_input = right_on;
  // Count advances only while the axis moves
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      encoder_position <= 32'h0000_0000;
    end else if (enc_run) begin
      encoder_position <= encoder_position + 32'h0000_0003;
    end
  end
endmodule

// File: test/test_reference_switch_stop_latch.sv
`timescale 1ns/1ps
`include "rssl_map.vh"
module test_reference_switch_stop_latch;
  localparam [31:0] a_cfg = {20'h0_0000, `RSSL_IDX_SWCFG, 2'h0};
  localparam [31:0] a_st  = {20'h0_0000, `RSSL_IDX_STATUS, 2'h0};
  localparam [31:0] a_pl  = {20'h0_0000, `RSSL_IDX_POS_LATCH, 2'h0};
  localparam [31:0] a_el  = {20'h0_0000, `RSSL_IDX_ENC_LATCH, 2'h0};
  localparam [31:0] a_vl  = {20'h0_0000, `RSSL_IDX_VLIM_L, 2'h0};
  localparam [31:0] a_vr  = {20'h0_0000, `RSSL_IDX_VLIM_R, 2'h0};
  localparam [31:0] a_wt  = {20'h0_0000, `RSSL_IDX_WAIT, 2'h0};
  localparam [31:0] neg   = 32'hFFFF_FFF0;
  localparam [31:0] fwd   = 32'h0000_0010;
  reg        clk_sys = 1'b0, rst_b = 1'b0;
  reg [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  reg [31:0] ramp_actual_position = 0, ramp_velocity = 0;
  reg        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg        s_axi_arvalid = 0, s_axi_rready = 0, stall_event = 0;
  reg        left_on = 0, right_on = 0, enc_run = 0, pre;
  reg [3:0]  s_axi_wstrb = 4'hF;
  wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire       s_axi_rvalid, motor_halt_r, halt_soft_r, halt_waiting_r;
  wire       left_switch_input, right_switch_input;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, encoder_position;
  int        err_count = 0, cmp_count = 0, wcnt = 0, i;
  reg [31:0] seed = 32'h0000_e3be, d, enc;
  reg [1:0]  r;

  rssl_top dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .left_switch_input(left_switch_input),
    .right_switch_input(right_switch_input),
    .ramp_actual_position(ramp_actual_position),
    .encoder_position(encoder_position), .ramp_velocity(ramp_velocity),
    .stall_event(stall_event), .motor_halt_r(motor_halt_r),
    .halt_soft_r(halt_soft_r), .halt_waiting_r(halt_waiting_r)
  );
  rssl_partner ptn_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .left_on(left_on),
    .right_on(right_on), .enc_run(enc_run),
    .left_switch_input(left_switch_input),
    .right_switch_input(right_switch_input),
    .encoder_position(encoder_position)
  );

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (halt_waiting_r) wcnt <= wcnt + 1;

  // ****************
  // Helpers
  // ****************
  function automatic [31:0] xs(input [31:0] x);
    reg [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction
  function automatic [31:0] cfg_rb(input [31:0] v);
    cfg_rb = v & `RSSL_SWCFG_MASK;
  endfunction
  task automatic chk(input string n, input [31:0] s, input [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input [31:0] a, input [31:0] v, input [1:0] e);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, e});
  endtask
  task automatic rd(input [31:0] a, output [31:0] v, output [1:0] e);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    v = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input string n, input [31:0] a, input [31:0] e);
    rd(a, d, r);
    chk(n, d, e);
  endtask
  task automatic cfg(input [31:0] v);
    wr(a_cfg, v, `RSSL_RESP_OKAY);
  endtask
  task automatic sc(input [31:0] c, input [31:0] v, input l, input rt,
                    input e);
    cfg(c);
    ramp_velocity <= v;
    left_on <= l;
    right_on <= rt;
    tick(8);
    chk("halt", {31'h0, motor_halt_r}, {31'h0, e});
    chk("soft", {31'h0, halt_soft_r}, {31'h0, c[11]});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    give_verdict;
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk("swcfg", a_cfg, `RSSL_SWCFG_RST);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      cfg(seed);
      rchk("swcfg", a_cfg, cfg_rb(seed));
    end
    s_axi_wstrb <= 4'h3;
    wr(a_vl, 32'h1234_5678, `RSSL_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rchk("strobe", a_vl,
         (`RSSL_VLIM_L_RST & 32'hFFFF_0000) | 32'h0000_5678);
    wr(32'h0000_0100, seed, `RSSL_RESP_SLVERR);
    rd(32'h0000_2000, d, r);
    chk("rresp", {30'h0, r}, {30'h0, `RSSL_RESP_SLVERR});
    sc(32'h0000_0001, neg, 1, 0, 1);
    sc(32'h0000_0001, fwd, 1, 0, 0);
    sc(32'h0000_0001, neg, 0, 0, 0);
    sc(32'h0000_0000, neg, 1, 0, 0);
    sc(32'h0000_0801, neg, 1, 0, 1);
    sc(32'h0000_0005, neg, 0, 0, 1);
    sc(32'h0000_0005, neg, 1, 0, 0);
    sc(32'h0000_0002, fwd, 0, 1, 1);
    sc(32'h0000_000A, fwd, 0, 0, 1);
    sc(32'h0000_0012, fwd, 1, 0, 1);
    sc(32'h0000_0012, fwd, 0, 1, 0);
    sc(32'h0000_0003, 32'h0, 1, 1, 0);
    wr(a_vl, 32'h0000_1000, `RSSL_RESP_OKAY);
    wr(a_vr, 32'h0000_2000, `RSSL_RESP_OKAY);
    ramp_actual_position <= 32'h0000_3000;
    sc(32'h0000_2000, fwd, 0, 0, 1);
    sc(32'h0000_0000, fwd, 0, 0, 0);
    ramp_actual_position <= 32'h0000_0800;
    sc(32'h0000_1000, neg, 0, 0, 1);
    sc(32'h0000_1000, fwd, 0, 0, 0);
    ramp_actual_position <= 32'h0000_1800;
    sc(32'h0000_5000, neg, 0, 0, 1);
    sc(32'h0000_1000, neg, 0, 0, 0);
    enc_run <= 1'b1;
    tick(7);
    enc_run <= 1'b0;
    tick(1);
    enc = encoder_position;
    for (i = 5; i < 9; i++) begin
      seed = xs(seed);
      pre = (i == 6) || (i == 8);
      cfg(32'h0);
      left_on <= (i < 7) && pre;
      right_on <= (i > 6) && pre;
      tick(8);
      cfg(32'h0000_0200 | (32'h1 << i));
      ramp_actual_position <= seed;
      if (i < 7) left_on <= !pre;
      else right_on <= !pre;
      tick(8);
      ramp_actual_position <= ~seed;
      if (i < 7) left_on <= pre;
      else right_on <= pre;
      tick(8);
      rchk("pos latch", a_pl, seed);
      rchk("enc latch", a_el, enc);
      rd(a_st, d, r);
      chk("latch flag", {31'h0, d[i < 7 ? 2 : 3]}, 32'h1);
      wr(a_st, `RSSL_W1C_MASK, `RSSL_RESP_OKAY);
    end
    wr(a_wt, 32'h0000_0005, `RSSL_RESP_OKAY);
    ramp_velocity <= fwd;
    tick(4);
    cfg(32'h0000_0400);
    stall_event <= 1'b1;
    tick(1);
    stall_event <= 1'b0;
    tick(3);
    chk("stall halt", {31'h0, motor_halt_r}, 32'h1);
    i = wcnt;
    cfg(32'h0);
    tick(20);
    chk("wait cycles", wcnt - i, 32'h0000_0005);
    chk("released", {31'h0, motor_halt_r}, 32'h0);
    stall_event <= 1'b1;
    tick(1);
    stall_event <= 1'b0;
    tick(3);
    chk("no stall halt", {31'h0, motor_halt_r}, 32'h0);
    give_verdict;
  end
endmodule

bind rssl_top rssl_assertions chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .motor_halt_r(motor_halt_r), .halt_waiting_r(halt_waiting_r)
);
